// >>> sim/sbl_ctl_model.sv
// Purpose: Decode and timing side that starts the load commands
// Assumes: Caller is at a falling clock edge when it calls issue
// Notes:   Lines it releases show the inverse of their last value
`timescale 1ns/100ps
`default_nettype none
module sbl_ctl_model (
  input  wire logic        clk_i,
  output logic             start_o,
  output logic [23:0]      instr_o,
  output logic [4:0]       z_o,
  output logic [23:0]      acc_o
);
  // Quiet lines at time zero
  initial begin
    start_o = 1'b0;
    instr_o = 24'h000000;
    z_o     = 5'h00;
    acc_o   = 24'h000000;
  end

  // One start pulse, word and operand held until the taking edge
  task automatic issue(input logic [23:0] ins, input logic [4:0] z,
                       input logic [23:0] a);
    start_o = 1'b1;
    instr_o = ins;
    z_o     = z;
    acc_o   = a;
    @(posedge clk_i);
    @(negedge clk_i);
    start_o = 1'b0;
    instr_o = ~ins;
    z_o     = ~z;
    acc_o   = ~a;
  endtask : issue
endmodule : sbl_ctl_model
`default_nettype wire

// >>> sim/tb.sv
// Purpose: Self-checking bench for the serial bit-load datapath
// Assumes: Inputs change on falling edges; checks at falling edges
// Notes:   Expectations come from the shift arithmetic alone
`timescale 1ns/100ps
`default_nettype none
module tb;
  import sbl_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        start;
  logic        busy;
  logic        done;
  logic [23:0] instr;
  logic [23:0] acc_in;
  logic [23:0] acc_out;
  logic [4:0]  z;
  logic [4:0]  j;
  int          mismatches = 0;
  int          checks     = 0;

  sbl_load_cmd #(.ACC_W(24)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .start_i(start), .instr_i(instr), .z_i(z), .acc_i(acc_in),
    .acc_o(acc_out), .j_o(j), .busy_o(busy), .done_o(done));
  sbl_ctl_model CTL (.clk_i(clk_i), .start_o(start), .instr_o(instr),
    .z_o(z), .acc_o(acc_in));

  // Clock, 50 ns period
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Compare tasks, one per result width
  task automatic cmp24(input logic [23:0] g, e, input string w);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: %s got %h want %h", $time, w, g, e);
    end
  endtask : cmp24
  task automatic cmp5(input logic [4:0] g, e, input string w);
    cmp24({19'h0, g}, {19'h0, e}, w);
  endtask : cmp5
  task automatic cmp1(input logic g, e, input string w);
    cmp24({23'h0, g}, {23'h0, e}, w);
  endtask : cmp1

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // One command start to done; poke gives a start while busy
  task automatic run_cmd(input sbl_cmd_t c, input logic [4:0] zz,
                         input logic [23:0] a, input bit poke);
    logic [8:0]  fld;
    logic [4:0]  j0;
    logic [23:0] fin;
    logic [23:0] mid;
    logic        sb;
    logic        on;
    bit          jbad;
    int          n;
    sb   = (c == SBL_CMD_SET_BIT);
    on   = (c == SBL_CMD_ONES);
    fld  = sb ? FLD_SET_BIT : (on ? FLD_LOAD_ONES : FLD_LOAD_ZERO);
    j0   = sb ? ~zz : J_PRESET_FULL;
    fin  = sb ? ((zz < 5'h18) ? 24'h000001 << zz : 24'h0) : {24{on}};
    mid  = (a >> 12) | (sb ? ((zz < 5'h0c) ? 24'h001000 << zz : 24'h0)
                           : {{12{on}}, 12'h000});
    CTL.issue({GEN_OPCODE, 3'h0, fld, 1'b0, sb ? zz : 5'h00}, zz, a);
    cmp24(acc_out, a, "initial load");
    cmp5(j, j0, "counter preload");
    n    = 1;
    jbad = 1'b0;
    while (done !== 1'b1 && n < 40) begin
      if (j !== j0 + 5'(n - 1)) jbad = 1'b1;
      if (n == 13) cmp24(acc_out, mid, "half rotated");
      if (poke && n == 5)
        CTL.issue({GEN_OPCODE, 3'h0, FLD_LOAD_ONES, 6'h00}, 5'h00, a);
      else
        @(negedge clk_i);
      n++;
    end
    cmp1(jbad, 1'b0, "counter steps");
    cmp5(5'(n), 5'h19, "latency");
    cmp24(acc_out, fin, "result");
    cmp5(j, j0 + SHIFT_COUNT, "final count");
    cmp1(busy, 1'b0, "busy at done");
    if (n >= 40) begin
      mismatches++;
      give_verdict();
    end
  endtask : run_cmd

  // Set-one-bit across boundary positions, back to back
  task automatic t_set_bits;
    logic [4:0] zs [7] = '{5'h00, 5'h01, 5'h0b, 5'h0c, 5'h17, 5'h18, 5'h1f};
    foreach (zs[i]) run_cmd(SBL_CMD_SET_BIT, zs[i], 24'ha5c3f0, 1'b0);
    $display("test set_bits done");
  endtask : t_set_bits

  // Clear and all-ones loads, then a start while busy
  task automatic t_loads;
    run_cmd(SBL_CMD_ZERO, 5'h05, 24'h5a5a5a, 1'b0);
    run_cmd(SBL_CMD_ONES, 5'h05, 24'h0f0f0f, 1'b0);
    run_cmd(SBL_CMD_SET_BIT, 5'h07, 24'hffffff, 1'b1);
    $display("test loads done");
  endtask : t_loads

  // Words outside the command set are ignored
  task automatic t_refuse;
    logic [23:0] bad [3] = '{{6'h06, 3'h0, FLD_SET_BIT, 6'h03},
      {GEN_OPCODE, 3'h0, FLD_SET_BIT, 6'h23},
      {GEN_OPCODE, 3'h0, 9'h019, 6'h03}};
    logic [23:0] keep;
    bit          act;
    keep = acc_out;
    act  = 1'b0;
    foreach (bad[i]) begin
      CTL.issue(bad[i], 5'h03, 24'h123456);
      @(negedge clk_i);
    end
    repeat (30) begin
      if (busy !== 1'b0 || done !== 1'b0) act = 1'b1;
      @(negedge clk_i);
    end
    cmp1(act, 1'b0, "refused start");
    cmp24(acc_out, keep, "refused keeps acc");
    $display("test refuse done");
  endtask : t_refuse

  // Reset in mid-shift clears everything and ends the command
  task automatic t_reset;
    CTL.issue({GEN_OPCODE, 3'h0, FLD_SET_BIT, 6'h02}, 5'h02, 24'h0000ff);
    repeat (5) @(negedge clk_i);
    rst_i = 1'b1;
    #1;
    cmp24(acc_out, ACC_RESET, "reset acc");
    cmp5(j, J_RESET, "reset count");
    cmp1(busy, 1'b0, "reset busy");
    @(negedge clk_i);
    rst_i = 1'b0;
    repeat (30) @(negedge clk_i);
    cmp1(done, 1'b0, "no done after reset");
    $display("test reset done");
  endtask : t_reset

  // Main sequence
  initial begin
    rst_i = 1'b1;
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    t_set_bits();
    t_loads();
    t_refuse();
    t_reset();
    give_verdict();
  end
endmodule : tb
`default_nettype wire

// >>> src/sbl_adder_if.sv
// Purpose: Carrier between the sequencer and the serial full adder
// Assumes: Both ends run on the same clock
// Notes:   ctl drives the adder inputs, add returns sum and carry
`timescale 1ns/100ps
`default_nettype none
interface sbl_adder_if;
  logic a_in;
  logic b_in;
  logic carry_set;
  logic carry_clr;
  logic sum;
  logic carry;

  modport ctl (output a_in, b_in, carry_set, carry_clr,
               input  sum, carry);
  modport add (input  a_in, b_in, carry_set, carry_clr,
               output sum, carry);
endinterface : sbl_adder_if
`default_nettype wire

// >>> src/sbl_load_cmd.sv
// Purpose: Serial execution of set-one-bit, load-zeros, load-ones
// Assumes: Decode/timing logic on the same clock gives start and operand
// Notes:   Accumulator rotates right through a one-bit serial adder
//
// What this block does
// - Set-one-bit leaves a one at position Z, zeros elsewhere.
// - Z above 23 sets no bit; accumulator ends all zero.
// - Set-one-bit is opcode 05, field 030, bit five zero, Z five bits.
// - On start of set-one-bit, counter takes inverse of Z low bits.
// - Each shift rotates accumulator right, adder output into bit 23.
// - Set-one-bit inserts zero except one when counter is 37 octal.
// - Preload makes counter hit 37 octal as bit Z leaves bit 0.
// - Adder B one needs decode, both instruction bits, counter at max.
// - Carry stays cleared during set-one-bit and load-zeros shifting.
// - Shift enable is generic decode, shift timing and bit five low.
// - Load-zeros shifts 24 places with adder idle, clearing accumulator.
// - Load-ones holds carry set for 24 shifts, giving all ones.
`timescale 1ns/100ps
`default_nettype none
module sbl_load_cmd
  import sbl_pkg::*;
#(
  parameter int unsigned ACC_W = 24
)(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              start_i,
  input  wire logic [23:0]       instr_i,
  input  wire logic [4:0]        z_i,
  input  wire logic [ACC_W-1:0]  acc_i,
  output logic      [ACC_W-1:0]  acc_o,
  output logic      [4:0]        j_o,
  output logic                   busy_o,
  output logic                   done_o
);

  // Shift length and counter arithmetic are fixed to a 24-bit word
  generate
    if (ACC_W != 24) begin : g_bad_width
      $error("sbl_load_cmd: ACC_W must be 24");
    end
  endgenerate

  // Command decode of an instruction word
  function automatic sbl_cmd_t cmd_of(input logic [23:0] iw);
    sbl_cmd_t c;
    c = SBL_CMD_NONE;
    if (iw[OPC_HI:OPC_LO] == GEN_OPCODE && !iw[BIT_FIVE]) begin
      case (iw[FLD_HI:FLD_LO])
        FLD_SET_BIT:   c = SBL_CMD_SET_BIT;
        FLD_LOAD_ZERO: c = SBL_CMD_ZERO;
        FLD_LOAD_ONES: c = SBL_CMD_ONES;
        default:       c = SBL_CMD_NONE;
      endcase
    end
    return c;
  endfunction : cmd_of

  sbl_state_t          state_q, state_d;
  sbl_cmd_t            cmd_q, start_cmd;
  logic [23:0]         instr_q;
  logic [4:0]          z_q;
  logic [ACC_W-1:0]    acc_q, acc_d;
  logic [4:0]          j_q, j_d;
  logic [4:0]          sh_cnt_q, sh_cnt_d;
  logic                busy_q, done_q;
  logic                start_ok, last_shift;
  logic                generic_cmd_decode;
  logic                state_six_timing;
  logic                instr_bit_five;
  logic                instr_bit_nine_inv;
  logic                instr_bit_ten_inv;
  logic                shift_count_at_max;
  logic                acc_shift_right_en;
  logic                adder_b_one_gate;
  logic                set_bit_run, ones_run;

  sbl_adder_if adder_if ();

  sbl_serial_adder u_adder (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .add_if (adder_if.add)
  );

  // Start acceptance
  assign start_cmd = cmd_of(instr_i);
  assign start_ok  = start_i && (state_q == SBL_ST_IDLE)
                   && (start_cmd != SBL_CMD_NONE);

  // Named decode terms from the latched instruction, state and counters
  assign generic_cmd_decode = (instr_q[OPC_HI:OPC_LO] == GEN_OPCODE);
  assign state_six_timing   = (state_q == SBL_ST_SHIFT);
  assign instr_bit_five     = instr_q[BIT_FIVE];
  assign instr_bit_nine_inv = instr_q[BIT_NINE];   // Latched copy, active
  assign instr_bit_ten_inv  = instr_q[BIT_TEN];    // Latched copy, active
  assign shift_count_at_max = (j_q == J_MAX);
  assign acc_shift_right_en = generic_cmd_decode && state_six_timing
                            && !instr_bit_five;
  assign set_bit_run        = acc_shift_right_en
                            && (cmd_q == SBL_CMD_SET_BIT);
  assign ones_run           = acc_shift_right_en
                            && (cmd_q == SBL_CMD_ONES);
  assign last_shift         = (sh_cnt_q == SHIFT_LAST);

  // Adder B one only at counter maximum
  assign adder_b_one_gate = instr_bit_ten_inv && instr_bit_nine_inv
                          && generic_cmd_decode && shift_count_at_max
                          && set_bit_run;

  // Adder inputs: A never used, carry forced set for load-ones start and all its shifts but the last, forced clear otherwise
  assign adder_if.a_in      = 1'b0;
  assign adder_if.b_in      = adder_b_one_gate;
  assign adder_if.carry_set = (start_ok && start_cmd == SBL_CMD_ONES)
                            || (ones_run && !last_shift);
  assign adder_if.carry_clr = !adder_if.carry_set;

  // Next-state values
  assign state_d  = start_ok ? SBL_ST_SHIFT
                  : (acc_shift_right_en && last_shift) ? SBL_ST_IDLE
                  : state_q;
  assign acc_d    = start_ok ? acc_i
                  : acc_shift_right_en ? {adder_if.sum, acc_q[ACC_W-1:1]}
                  : acc_q;
  assign j_d      = (start_ok && start_cmd == SBL_CMD_SET_BIT) ? ~z_i
                  : start_ok ? J_PRESET_FULL
                  : acc_shift_right_en ? j_q + 5'h01
                  : j_q;
  assign sh_cnt_d = start_ok ? 5'h00
                  : acc_shift_right_en ? sh_cnt_q + 5'h01
                  : sh_cnt_q;

  // Sequencer, accumulator and counters
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q  <= SBL_ST_IDLE;
      cmd_q    <= SBL_CMD_NONE;
      instr_q  <= 24'h000000;
      z_q      <= 5'h00;
      acc_q    <= ACC_RESET;
      j_q      <= J_RESET;
      sh_cnt_q <= 5'h00;
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      acc_q    <= acc_d;
      j_q      <= j_d;
      sh_cnt_q <= sh_cnt_d;
      busy_q   <= (state_d == SBL_ST_SHIFT);
      done_q   <= acc_shift_right_en && last_shift;
      if (start_ok) begin
        cmd_q   <= start_cmd;
        instr_q <= instr_i;
        z_q     <= z_i;
      end
    end
  end

  // Outputs straight from flops
  assign acc_o  = acc_q;
  assign j_o    = j_q;
  assign busy_o = busy_q;
  assign done_o = done_q;

  // Checks on the datapath
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Counter preload, rotation and holding between commands
  j_preload_a: assert property (
    start_ok && start_cmd == SBL_CMD_SET_BIT |=> j_q == ~$past(z_i))
    else $error("counter preload wrong");
  acc_rotate_a: assert property (
    acc_shift_right_en |=> acc_q[22:0] == $past(acc_q[23:1]))
    else $error("accumulator did not rotate");
  j_step_a: assert property (
    acc_shift_right_en |=> j_q == $past(j_q) + 5'h01)
    else $error("counter did not advance");
  acc_hold_a: assert property (
    !acc_shift_right_en && !start_ok |=> $stable(acc_q) && $stable(j_q))
    else $error("accumulator moved while idle");

  // Serial adder inputs and the carry flip-flop
  b_one_a: assert property (
    set_bit_run && shift_count_at_max |-> adder_if.sum && adder_b_one_gate)
    else $error("one not inserted at max");
  zero_fill_a: assert property (
    set_bit_run && !shift_count_at_max |-> !adder_if.sum)
    else $error("stray one inserted");
  b_gate_only_a: assert property (
    adder_b_one_gate |-> set_bit_run && shift_count_at_max
                         && instr_q[BIT_NINE] && instr_q[BIT_TEN])
    else $error("adder B driven outside set-one-bit");
  carry_clear_a: assert property (
    acc_shift_right_en && cmd_q != SBL_CMD_ONES |-> !adder_if.carry)
    else $error("carry not cleared");
  carry_held_a: assert property (
    ones_run |-> adder_if.carry && adder_if.sum)
    else $error("carry not held set");
  carry_end_a: assert property (
    done_o |-> !adder_if.carry)
    else $error("carry left set after shifting");

  // Shift length and final contents
  shift_len_a: assert property (
    start_ok |=> busy_o [*8] ##1 busy_o [*8] ##1 busy_o [*8]
                 ##1 done_o && !busy_o)
    else $error("shift length not 24");
  shift_stop_a: assert property (
    done_o |-> sh_cnt_q == SHIFT_COUNT)
    else $error("shift count not 24");
  set_result_a: assert property (
    done_o && cmd_q == SBL_CMD_SET_BIT |-> acc_o == (24'h000001 << z_q))
    else $error("set-one-bit result wrong");
  zero_result_a: assert property (
    done_o && cmd_q == SBL_CMD_ZERO |-> acc_o == 24'h000000)
    else $error("load-zeros result wrong");
  ones_result_a: assert property (
    done_o && cmd_q == SBL_CMD_ONES |-> acc_o == 24'hffffff)
    else $error("load-ones result wrong");
  j_final_a: assert property (
    done_o |-> j_q == ((cmd_q == SBL_CMD_SET_BIT) ? 5'h17 - z_q : 5'h17))
    else $error("final counter wrong");

endmodule : sbl_load_cmd
`default_nettype wire

// >>> src/sbl_pkg.sv
// Purpose: Shared constants and types for the serial bit-load datapath
// Assumes: 24-bit accumulator, 5-bit shift counter, one 20 MHz clock
// Notes:   Field values are octal figures written in hexadecimal
package sbl_pkg;

  // Instruction word layout
  localparam int unsigned INSTR_W      = 24;
  localparam int unsigned OPC_HI       = 23;
  localparam int unsigned OPC_LO       = 18;
  localparam int unsigned FLD_HI       = 14;
  localparam int unsigned FLD_LO       = 6;
  localparam int unsigned BIT_FIVE     = 5;
  localparam int unsigned BIT_NINE     = 9;
  localparam int unsigned BIT_TEN      = 10;

  // Generic group opcode and sub-field codes
  localparam logic [5:0] GEN_OPCODE    = 6'h05;   // 05 octal
  localparam logic [8:0] FLD_SET_BIT   = 9'h018;  // 030 octal
  localparam logic [8:0] FLD_LOAD_ZERO = 9'h000;
  localparam logic [8:0] FLD_LOAD_ONES = 9'h040;

  // Shift counter figures
  localparam int unsigned J_W          = 5;
  localparam logic [4:0] J_MAX         = 5'h1f;   // 37 octal
  localparam logic [4:0] J_RESET       = 5'h00;
  localparam logic [4:0] J_PRESET_FULL = 5'h1f;   // Inverse of zero operand

  // Number of right shifts per command
  localparam logic [4:0] SHIFT_COUNT   = 5'h18;   // 24 places
  localparam logic [4:0] SHIFT_LAST    = 5'h17;

  // Values after reset
  localparam logic [23:0] ACC_RESET    = 24'h000000;

  typedef enum logic [0:0] {
    SBL_ST_IDLE  = 1'b0,
    SBL_ST_SHIFT = 1'b1
  } sbl_state_t;

  typedef enum logic [1:0] {
    SBL_CMD_NONE    = 2'b00,
    SBL_CMD_SET_BIT = 2'b01,
    SBL_CMD_ZERO    = 2'b10,
    SBL_CMD_ONES    = 2'b11
  } sbl_cmd_t;

endpackage : sbl_pkg

// >>> src/sbl_serial_adder.sv
// Purpose: One-bit serial full adder with its carry flip-flop
// Assumes: Set has priority over clear; otherwise carry takes the carry-out
// Notes:   Sum is combinational from the inputs and the stored carry
`timescale 1ns/100ps
`default_nettype none
module sbl_serial_adder
  import sbl_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  sbl_adder_if.add  add_if
);

  logic carry_q;
  logic carry_d;
  logic maj;

  // Sum and carry-out of the three inputs
  assign add_if.sum   = add_if.a_in ^ add_if.b_in ^ carry_q;
  assign maj          = (add_if.a_in & add_if.b_in)
                      | (carry_q & (add_if.a_in ^ add_if.b_in));
  assign carry_d      = add_if.carry_set ? 1'b1
                      : add_if.carry_clr ? 1'b0 : maj;
  assign add_if.carry = carry_q;

  // Carry flip-flop
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      carry_q <= 1'b0;
    end else begin
      carry_q <= carry_d;
    end
  end

endmodule : sbl_serial_adder
`default_nettype wire
